// *** verilog/trace_status_regs.svh ***
// Purpose: constants for the program trace status block
// Assumes: 3-bit fetch status bus and 2-bit history flush status
// Notes: definitions only
`ifndef TRACE_STATUS_REGS_SVH
`define TRACE_STATUS_REGS_SVH

`define VF_NONE 3'h0
`define VF_SEQ 3'h1
`define VF_NOT_TAKEN 3'h2
`define VF_SYNC_CHANGE 3'h3
`define VF_EXCEPTION 3'h4
`define VF_INDIRECT 3'h5
`define VF_DIRECT 3'h6
`define VF_NOT_TAKEN_ALT 3'h7
`define VF_FLUSH_MAX 3'h5
`define HISTORY_FLUSH_STATUS_NONE 2'h0
`define HISTORY_FLUSH_STATUS_MAX 2'h2
`define HISTORY_FLUSH_STATUS_DEBUG 2'h3
`define EVENT_FIFO_DEPTH 8

`endif

// *** verilog/trace_status_pkg.sv ***
// Purpose: types shared by the program trace status block
// Assumes: nothing
// Notes: constants live in trace_status_regs.svh
package trace_status_pkg;

   // kind of the last fetched instruction as seen by the core
   typedef enum logic [2:0] {
      KIND_NONE,
      KIND_SEQ,
      KIND_NOT_TAKEN,
      KIND_EXCEPTION,
      KIND_INDIRECT,
      KIND_SPECIAL,
      KIND_DIRECT
   } fetch_kind_t;

   // one core fetch event
   typedef struct packed {
      fetch_kind_t kind;
      logic [2:0] queue_flush;
      logic [1:0] hist_flush;
      logic ext_code;
   } fetch_event_t;

   localparam int EVENT_W = $bits(fetch_event_t);

endpackage : trace_status_pkg

// *** verilog/event_fifo.sv ***
// Purpose: small FIFO between core fetch events and the status reporter
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready_o and out_valid_o come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module event_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_reg[rd_reg];

   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = AW'(wr_reg + 1'b1);
      end
      if (pop) begin
         rd_next = AW'(rd_reg + 1'b1);
      end
      if (push && !pop) begin
         cnt_next = (AW+1)'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = (AW+1)'(cnt_reg - 1'b1);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         in_ready_o <= (cnt_next != (AW+1)'(DEPTH));
         out_valid_o <= (cnt_next != '0);
      end
   end

   // storage has no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
endmodule : event_fifo
`default_nettype wire

// *** verilog/sync_request_ctrl.sv ***
// Purpose: holds the trace-sync request set by development port commands
// Assumes: commands arrive as one-cycle pulses
// Notes: a change stays pending until the reporter acknowledges it
`timescale 1ns/1ps
`default_nettype none
module sync_request_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // development port command
   input wire logic cmd_valid_i,
   input wire logic cmd_assert_i,
   // reporter side
   input wire logic change_ack_i,
   output logic sync_active_o,
   output logic change_pending_o
);
   logic sync_next, pend_next;

   always_comb begin
      sync_next = sync_active_o;
      pend_next = change_pending_o & ~change_ack_i;
      if (cmd_valid_i && (cmd_assert_i != sync_active_o)) begin
         sync_next = cmd_assert_i;
         pend_next = 1'b1; // set wins over acknowledge
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_active_o <= 1'b0;
         change_pending_o <= 1'b0;
      end else begin
         sync_active_o <= sync_next;
         change_pending_o <= pend_next;
      end
   end
endmodule : sync_request_ctrl
`default_nettype wire

// *** verilog/program_trace_status.sv ***
// Purpose: drives fetch status, history flush status and trace-cycle marks
// Assumes: core events synchronous to clk_i; one report per clock
// Notes: events wait in a FIFO while flush or debug slots are reported
// Function
// - Fetch bus carries type reports or flush counts, flush only in non-type clocks.
// - Codes 000 none, 001 sequential, 010 not taken, 011 sync change; next is type.
// - 100 exception, 101 indirect, 110 direct, 111 not taken; next is flush count.
// - Flush slot carries count 000..101; 110 reserved; 111 means type info.
// - Only type code allowed in a flush slot is 111, branch not taken; debug entry in a flush slot still reports 100 here.
// - History flush status gives 0..2 flushed; 11 only for debug mode.
// - Debug entry reports 100 and makes a trace cycle visible.
// - In debug mode fetch bus is 000 and history flush 11.
// - Sync change during debug is reported as 011 first after debug.
// - Without sync change, first report after debug is 101.
// - First fetch after debug is marked as trace cycle and visible.
// - Return, state write, sync, special register writes report 101 and mark next fetch.
// - While sync asserted, traced fetches are shown: full external, address-only internal.
// - Sync request is set and cleared by development port commands.
`timescale 1ns/1ps
`default_nettype none
`include "trace_status_regs.svh"
module program_trace_status
   import trace_status_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // core fetch events
   input wire logic event_valid_i,
   output logic event_ready_o,
   input wire fetch_event_t event_i,
   // core mode and show configuration
   input wire logic debug_mode_i,
   input wire logic show_indirect_i,
   // development port sync command
   input wire logic sync_cmd_valid_i,
   input wire logic sync_cmd_assert_i,
   // status pins
   output logic [2:0] fetch_status_bus_o,
   output logic [1:0] history_flush_status_o,
   // trace cycle marks
   output logic trace_cycle_o,
   output logic show_full_o,
   output logic show_addr_only_o,
   output logic sync_active_o
);
   typedef enum {
      ST_TYPE,
      ST_FLUSH,
      ST_DEBUG,
      ST_EXIT
   } report_state_t;

   report_state_t state_reg, state_next;
   logic [2:0] vf_reg, vf_next;
   logic [1:0] history_flush_status_reg, history_flush_status_next;
   logic [2:0] flush_reg, flush_next;
   logic trace_reg, trace_next;
   logic full_reg, full_next;
   logic addr_reg, addr_next;
   logic ext_reg, ext_next;
   logic ev_valid, ev_pop, sync_active, sync_pending, sync_ack;
   logic [EVENT_W-1:0] ev_raw;
   fetch_event_t ev;
   logic mark, forced, mark_ext;

   event_fifo #(
      .WIDTH(EVENT_W),
      .DEPTH(`EVENT_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(event_valid_i),
      .in_ready_o(event_ready_o),
      .in_data_i(event_i),
      .out_valid_o(ev_valid),
      .out_ready_i(ev_pop),
      .out_data_o(ev_raw)
   );

   sync_request_ctrl u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .cmd_valid_i(sync_cmd_valid_i),
      .cmd_assert_i(sync_cmd_assert_i),
      .change_ack_i(sync_ack),
      .sync_active_o(sync_active),
      .change_pending_o(sync_pending)
   );

   assign ev = fetch_event_t'(ev_raw);

   always_comb begin
      state_next = state_reg;
      vf_next = `VF_NONE;
      history_flush_status_next = `HISTORY_FLUSH_STATUS_NONE;
      flush_next = flush_reg;
      ext_next = ext_reg;
      ev_pop = 1'b0;
      sync_ack = 1'b0;
      mark = 1'b0;
      forced = 1'b0;
      mark_ext = 1'b0;
      case (state_reg)
         ST_TYPE: begin
            if (debug_mode_i) begin
               vf_next = `VF_EXCEPTION;
               mark = 1'b1;
               forced = 1'b1;
               state_next = ST_DEBUG;
            end else if (sync_pending) begin
               vf_next = `VF_SYNC_CHANGE;
               sync_ack = 1'b1;
               mark = 1'b1;
               forced = 1'b1;
            end else if (ev_valid) begin
               ev_pop = 1'b1;
               mark_ext = ev.ext_code;
               history_flush_status_next = (ev.hist_flush > `HISTORY_FLUSH_STATUS_MAX) ? `HISTORY_FLUSH_STATUS_MAX : ev.hist_flush;
               flush_next = (ev.queue_flush > `VF_FLUSH_MAX) ? `VF_FLUSH_MAX : ev.queue_flush;
               ext_next = ev.ext_code;
               case (ev.kind)
                  KIND_SEQ: vf_next = `VF_SEQ;
                  KIND_NOT_TAKEN: vf_next = `VF_NOT_TAKEN;
                  KIND_EXCEPTION: begin
                     vf_next = `VF_EXCEPTION;
                     mark = 1'b1;
                     state_next = ST_FLUSH;
                  end
                  KIND_INDIRECT, KIND_SPECIAL: begin
                     vf_next = `VF_INDIRECT;
                     mark = 1'b1;
                     state_next = ST_FLUSH;
                  end
                  KIND_DIRECT: begin
                     vf_next = `VF_DIRECT;
                     state_next = ST_FLUSH;
                  end
                  default: vf_next = `VF_NONE;
               endcase
            end
         end
         ST_FLUSH: begin
            if (debug_mode_i) begin
               vf_next = `VF_EXCEPTION;
               mark = 1'b1;
               forced = 1'b1;
               state_next = ST_DEBUG;
            end else if (ev_valid && ev.kind == KIND_NOT_TAKEN) begin
               // a not-taken branch may fill the flush slot; flush stays owed
               ev_pop = 1'b1;
               vf_next = `VF_NOT_TAKEN_ALT;
               history_flush_status_next = (ev.hist_flush > `HISTORY_FLUSH_STATUS_MAX) ? `HISTORY_FLUSH_STATUS_MAX : ev.hist_flush;
            end else begin
               vf_next = flush_reg;
               state_next = ST_TYPE;
            end
         end
         ST_DEBUG: begin
            vf_next = `VF_NONE;
            history_flush_status_next = `HISTORY_FLUSH_STATUS_DEBUG;
            if (!debug_mode_i) begin
               state_next = ST_EXIT;
            end
         end
         ST_EXIT: begin
            mark = 1'b1;
            forced = 1'b1;
            mark_ext = ext_reg;
            if (sync_pending) begin
               vf_next = `VF_SYNC_CHANGE;
               sync_ack = 1'b1;
               state_next = ST_TYPE;
            end else begin
               vf_next = `VF_INDIRECT;
               flush_next = 3'h0;
               state_next = ST_FLUSH;
            end
         end
         default: begin
            state_next = ST_TYPE;
         end
      endcase
      trace_next = mark;
      full_next = mark & (forced | sync_active | show_indirect_i) & mark_ext;
      addr_next = mark & (forced | sync_active | show_indirect_i) & ~mark_ext;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_TYPE;
         vf_reg <= `VF_NONE;
         history_flush_status_reg <= `HISTORY_FLUSH_STATUS_NONE;
         flush_reg <= 3'h0;
         trace_reg <= 1'b0;
         full_reg <= 1'b0;
         addr_reg <= 1'b0;
         ext_reg <= 1'b0;
         sync_active_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         vf_reg <= vf_next;
         history_flush_status_reg <= history_flush_status_next;
         flush_reg <= flush_next;
         trace_reg <= trace_next;
         full_reg <= full_next;
         addr_reg <= addr_next;
         ext_reg <= ext_next;
         sync_active_o <= sync_active;
      end
   end

   assign fetch_status_bus_o = vf_reg;
   assign history_flush_status_o = history_flush_status_reg;
   assign trace_cycle_o = trace_reg;
   assign show_full_o = full_reg;
   assign show_addr_only_o = addr_reg;
endmodule : program_trace_status
`default_nettype wire

// *** tb/trace_capture_model.sv ***
// Purpose: listening model of external trace capture hardware
// Assumes: samples both status buses on every clock
// Notes: counts sync reports and history flushes
`timescale 1ns/1ps
`default_nettype none
module trace_capture_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // status buses
   input wire logic [2:0] vf_i,
   input wire logic [1:0] history_flush_status_i,
   // capture totals
   output var int sync_count_o,
   output var int hist_total_o
);
   logic [2:0] prev;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev <= 3'h7;
         sync_count_o <= 0;
         hist_total_o <= 0;
      end else begin
         prev <= vf_i;
         if (vf_i == 3'h3 && prev <= 3'h2) sync_count_o <= sync_count_o + 1;
         if (history_flush_status_i != 2'h3) hist_total_o <= hist_total_o + int'(history_flush_status_i);
      end
   end
endmodule : trace_capture_model
`default_nettype wire

// *** tb/program_trace_status_asserts.sv ***
// Purpose: port checks for program_trace_status
// Assumes: single clock domain
// Notes: slot tracker follows the fetch status bus
`timescale 1ns/1ps
`default_nettype none
module program_trace_status_asserts (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic debug_mode_i,
   input wire logic [2:0] fetch_status_bus_o,
   input wire logic [1:0] history_flush_status_o,
   input wire logic trace_cycle_o,
   input wire logic show_full_o,
   input wire logic show_addr_only_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic [2:0] vf = fetch_status_bus_o;
   wire logic [1:0] fl = history_flush_status_o;
   wire logic shown = show_full_o || show_addr_only_o;
   logic in_flush;
   // high in a clock that is owed a flush count
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) in_flush <= 1'b0;
      else if (in_flush) in_flush <= (vf == 3'h7);
      else in_flush <= vf[2] && fl != 2'h3;
   end
   property p_reset_idle; $rose(resetn_i) |-> vf == 3'h0 && fl == 2'h0; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("status not idle after reset");
   property p_debug_entry; $rose(debug_mode_i) |=> vf == 3'h4 && trace_cycle_o && shown; endproperty
   a_debug_entry: assert property (p_debug_entry) else $error("debug entry report wrong");
   property p_debug_hold; debug_mode_i [*2] |=> vf == 3'h0 && fl == 2'h3; endproperty
   a_debug_hold: assert property (p_debug_hold) else $error("debug hold value wrong");
   property p_hist_debug; fl == 2'h3 |-> $past(debug_mode_i) || $past(debug_mode_i, 2); endproperty
   a_hist_debug: assert property (p_hist_debug) else $error("history code 11 outside debug");
   property p_no_reserved; in_flush |-> vf != 3'h6; endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved flush code");
   property p_type_slot; !in_flush |-> vf != 3'h7; endproperty
   a_type_slot: assert property (p_type_slot) else $error("111 in a type clock");
   property p_mark_kind; trace_cycle_o |-> vf == 3'h3 || vf == 3'h4 || vf == 3'h5; endproperty
   a_mark_kind: assert property (p_mark_kind) else $error("trace mark on wrong code");
   property p_show_one; shown |-> trace_cycle_o && !(show_full_o && show_addr_only_o); endproperty
   a_show_one: assert property (p_show_one) else $error("show pulse without single mark");
   property p_sync_show; trace_cycle_o && vf == 3'h3 |-> shown; endproperty
   a_sync_show: assert property (p_sync_show) else $error("sync report not shown");
   property p_debug_exit;
      $fell(debug_mode_i) |=> vf == 3'h0 && fl == 2'h3 ##1 trace_cycle_o && shown && (vf == 3'h3 || vf == 3'h5);
   endproperty
   a_debug_exit: assert property (p_debug_exit) else $error("debug exit report wrong");
   c_entry: cover property ($rose(debug_mode_i));
   c_sync: cover property (trace_cycle_o && vf == 3'h3);
   c_alt: cover property (in_flush && vf == 3'h7);
endmodule : program_trace_status_asserts
bind program_trace_status program_trace_status_asserts i_chk (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .debug_mode_i(debug_mode_i),
   .fetch_status_bus_o(fetch_status_bus_o),
   .history_flush_status_o(history_flush_status_o),
   .trace_cycle_o(trace_cycle_o),
   .show_full_o(show_full_o),
   .show_addr_only_o(show_addr_only_o)
);
`default_nettype wire

// *** tb/program_trace_status_test.sv ***
// Purpose: self-checking bench for program_trace_status
// Assumes: events queue up while debug stalls the reporter
// Notes: reports compared cycle by cycle with a queue model
`timescale 1ns/1ps
`default_nettype none
module program_trace_status_test;
   import trace_status_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic event_valid_i = 1'b0;
   logic event_ready_o;
   fetch_event_t event_i = '0;
   logic debug_mode_i = 1'b0;
   logic show_indirect_i = 1'b0;
   logic sync_cmd_valid_i = 1'b0;
   logic sync_cmd_assert_i = 1'b0;
   logic [2:0] fetch_status_bus_o;
   logic [1:0] history_flush_status_o;
   logic trace_cycle_o, show_full_o, show_addr_only_o, sync_active_o;
   int num_errors = 0;
   int checks_done = 0;
   int sync_count, hist_total, owed, n;
   int hist_exp = 0;
   logic [31:0] rnd = 32'h1C49DF5A;
   logic [5:0] exp_q[$];
   logic [5:0] got;
   fetch_event_t ev_q[$];
   always #12.5 clk_i = ~clk_i;
   program_trace_status i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .event_valid_i(event_valid_i),
      .event_ready_o(event_ready_o), .event_i(event_i), .debug_mode_i(debug_mode_i),
      .show_indirect_i(show_indirect_i), .sync_cmd_valid_i(sync_cmd_valid_i),
      .sync_cmd_assert_i(sync_cmd_assert_i), .fetch_status_bus_o(fetch_status_bus_o),
      .history_flush_status_o(history_flush_status_o), .trace_cycle_o(trace_cycle_o),
      .show_full_o(show_full_o), .show_addr_only_o(show_addr_only_o), .sync_active_o(sync_active_o));
   trace_capture_model i_cap (.clk_i(clk_i), .resetn_i(resetn_i), .vf_i(fetch_status_bus_o),
      .history_flush_status_i(history_flush_status_o), .sync_count_o(sync_count), .hist_total_o(hist_total));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task check(string name, logic [31:0] exp, logic [31:0] seen);
      checks_done++;
      if (exp !== seen) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task model(fetch_event_t e);
      logic [1:0] hc;
      logic [2:0] code;
      hc = (e.hist_flush > 2'h2) ? 2'h2 : e.hist_flush;
      hist_exp += int'(hc);
      if (owed >= 0 && e.kind == KIND_NOT_TAKEN) begin
         exp_q.push_back({3'h7, hc, 1'b0});
      end else begin
         if (owed >= 0) exp_q.push_back({owed[2:0], 2'h0, 1'b0});
         owed = -1;
         case (e.kind)
            KIND_NONE: code = 3'h0;
            KIND_SEQ: code = 3'h1;
            KIND_NOT_TAKEN: code = 3'h2;
            KIND_EXCEPTION: code = 3'h4;
            KIND_DIRECT: code = 3'h6;
            default: code = 3'h5;
         endcase
         exp_q.push_back({code, hc, e.kind inside {KIND_EXCEPTION, KIND_INDIRECT, KIND_SPECIAL}});
         if (code[2]) owed = (e.queue_flush > 3'h5) ? 5 : int'(e.queue_flush);
      end
   endtask : model
   task close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      for (int r = 0; r < 3; r++) begin
         @(posedge clk_i);
         #2 debug_mode_i = 1'b1;
         repeat (3) @(posedge clk_i);
         n = 0;
         for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            #2;
            if (event_ready_o !== 1'b1) break;
            rnd = lfsr(rnd);
            event_i = {fetch_kind_t'(3'(rnd % 7)), rnd[8:4], rnd[12]};
            event_valid_i = 1'b1;
            show_indirect_i = rnd[13];
            ev_q.push_back(event_i);
            n++;
         end
         event_valid_i = 1'b0;
         check("fifo_fill", 1, n >= 8 && n <= 9);
         if (r > 0) begin
            sync_cmd_assert_i = (r == 1);
            sync_cmd_valid_i = 1'b1;
            @(posedge clk_i);
            #2 sync_cmd_valid_i = 1'b0;
         end
         repeat (3) @(posedge clk_i);
         check("sync_level", r == 1, sync_active_o);
         #2 debug_mode_i = 1'b0;
         exp_q = {};
         exp_q.push_back({3'h0, 2'h3, 1'b0});
         exp_q.push_back({(r > 0) ? 3'h3 : 3'h5, 2'h0, 1'b1});
         owed = (r > 0) ? -1 : 0;
         while (ev_q.size() > 0) model(ev_q.pop_front());
         if (owed >= 0) exp_q.push_back({owed[2:0], 2'h0, 1'b0});
         // the edge after debug drops still shows the debug value, so compare from that edge on
         while (exp_q.size() > 0) begin
            @(posedge clk_i);
            #1 got = exp_q.pop_front();
            check("report", got, {fetch_status_bus_o, history_flush_status_o, trace_cycle_o});
         end
      end
      repeat (2) @(posedge clk_i);
      check("sync_reports", 2, sync_count);
      check("hist_total", hist_exp, hist_total);
      close_out();
   end
endmodule : program_trace_status_test
`default_nettype wire
